//--- common/crrt_pkg.sv
// Constants, types and the address decoder for the receiver register tail.
`default_nettype none

package crrt_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [7:0] ADDR_LOW_FIRST = 8'h00;
  localparam logic [7:0] ADDR_LOW_LAST = 8'h0F;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h3E;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h3F;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_TEST_FIRST = 8'h41;
  localparam logic [7:0] ADDR_TEST_LAST = 8'h6F;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int TEMP_CODE_W = 12;
  localparam int TEMP_LO_LSB = 4;
  localparam int TEMP_LO_BITS = 4;
  localparam int TEMP_HI_LSB = 4;
  localparam int CTRL_WR_GATE_BIT = 0;
  localparam int CTRL_PULLUP_LSB = 4;
  localparam int CTRL_PULLUP_W = 2;
  localparam int CTRL_TEST_LSB = 6;
  localparam int CTRL_TEST_W = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [11:0] TEMP_RESET = 12'h000;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************************
  // Pad pull-up codes and conversion scale
  // ****************************************************************
  localparam logic [1:0] PULLUP_OFF = 2'h0;
  localparam logic [1:0] PULLUP_500K = 2'h1;
  localparam logic [1:0] PULLUP_1000K = 2'h2;
  localparam logic [1:0] PULLUP_2000K = 2'h3;
  // Millivolts at the temperature sense pin per result code.
  localparam real TEMP_SENSE_MV_PER_CODE = 0.0392;

  // ****************************************************************
  // Address regions
  // ****************************************************************
  typedef enum logic [2:0] {
    REGION_LOW_BANK,
    REGION_EXT,
    REGION_TEMP_LO,
    REGION_TEMP_HI,
    REGION_CTRL,
    REGION_TEST,
    REGION_UNMAPPED
  } crrt_region_e;

  function automatic crrt_region_e crrt_region(input logic [7:0] addr);
    crrt_region_e r;
    r = REGION_UNMAPPED;
    if (addr <= ADDR_LOW_LAST) begin
      r = REGION_LOW_BANK;
    end else if (addr < ADDR_TEMP_LO) begin
      r = REGION_EXT;
    end else if (addr == ADDR_TEMP_LO) begin
      r = REGION_TEMP_LO;
    end else if (addr == ADDR_TEMP_HI) begin
      r = REGION_TEMP_HI;
    end else if (addr == ADDR_CTRL) begin
      r = REGION_CTRL;
    end else if (addr >= ADDR_TEST_FIRST && addr <= ADDR_TEST_LAST) begin
      r = REGION_TEST;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

//--- common/crrt_ctrl_if.sv
// Link between the register tail and its serial port control byte.
`timescale 1ns/1ps
`default_nettype none

interface crrt_ctrl_if;
  logic wrStb;
  logic [7:0] wrData;
  logic [7:0] value;

  modport ctrlReg (
    input wrStb,
    input wrData,
    output value
  );

  modport bank (
    output wrStb,
    output wrData,
    input value
  );
endinterface

`default_nettype wire

//--- hw/crrt_ctrl_reg.sv
// Serial port control byte: write gate, pad pull-up select, test bits.
`timescale 1ns/1ps
`default_nettype none

module crrt_ctrl_reg (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Control byte access
  crrt_ctrl_if.ctrlReg ctl
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;

  // ****************************************************************
  // Next value
  // ****************************************************************
  // All eight bits are stored as written, the test bits included, so
  // that a read shows exactly what the host put there.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctl.wrStb) begin
      ctrl_next = ctl.wrData; // [R3] [R4]
    end
  end

  // ****************************************************************
  // Register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= crrt_pkg::CTRL_RESET; // [R3] [R4]
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctl.value = ctrl_reg;

endmodule

`default_nettype wire

//--- hw/crrt_reg_tail.sv
// Register tail: temperature result bytes, serial port control, test range.
//
// Overview of operation
// R1: 12-bit temperature code read-only; low nibble at 0x3E[7:4], rest 0x3F.
// R2: Result code passes unscaled, one code per fixed pin voltage step.
// R3: Control bit 0 at 0x40 gates writes to 0x00-0x0F; reset blocks.
// R4: Control bits 5:4 pick pad pull-up 500k, 1000k or 2000k ohm.
// R5: Host writes only zero to control test bits 7 and 6.
// R6: Host never touches test addresses 0x41 through 0x6F.
// R7: Gated low-bank writes and writes to result bytes are dropped.
`timescale 1ns/1ps
`default_nettype none

module crrt_reg_tail #(
  parameter int TEMP_W = crrt_pkg::TEMP_CODE_W
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Byte access from the two-wire serial engine
  input wire logic hostRdEn,
  input wire logic hostWrEn,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  // Temperature converter result
  input wire logic [TEMP_W-1:0] tempCode,
  input wire logic tempCodeValid,
  // Registers below this tail, in other banks
  input wire logic [7:0] extRdData,
  output logic extWrEn,
  output logic [7:0] extWrAddr,
  output logic [7:0] extWrData,
  output logic lowBankWrBlocked,
  // Serial pad control and write gate state
  output logic [1:0] padPullupSelect,
  output logic lowBankWrAllow
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  crrt_ctrl_if ctl ();

  logic [TEMP_W-1:0] temp_reg;
  logic [TEMP_W-1:0] temp_next;
  logic [7:0] hiHold_reg;
  logic [7:0] hiHold_next;
  logic hiHeld_reg;
  logic hiHeld_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdValid_reg;
  logic rdValid_next;
  logic extWrEn_reg;
  logic extWrEn_next;
  logic [7:0] extWrAddr_reg;
  logic [7:0] extWrAddr_next;
  logic [7:0] extWrData_reg;
  logic [7:0] extWrData_next;
  logic blocked_reg;
  logic blocked_next;

  crrt_pkg::crrt_region_e wrRegion;
  crrt_pkg::crrt_region_e rdRegion;
  logic gateOpen;
  logic [7:0] tempLoByte;
  logic [7:0] tempHiByte;

  // ****************************************************************
  // Control byte
  // ****************************************************************
  crrt_ctrl_reg u_ctrl (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .ctl(ctl.ctrlReg)
  );

  assign wrRegion = crrt_pkg::crrt_region(hostAddr);
  assign rdRegion = crrt_pkg::crrt_region(hostAddr);
  assign ctl.wrStb = hostWrEn && (wrRegion == crrt_pkg::REGION_CTRL);
  assign ctl.wrData = hostWrData;
  assign gateOpen = ctl.value[crrt_pkg::CTRL_WR_GATE_BIT]; // [R3]

  // ****************************************************************
  // Result byte views
  // ****************************************************************
  // The low nibble of the code sits in the upper half of the low byte;
  // the lower half reads as zero.
  always_comb begin
    tempLoByte = crrt_pkg::READ_ZERO;
    tempLoByte[crrt_pkg::TEMP_LO_LSB +: crrt_pkg::TEMP_LO_BITS] =
      temp_reg[crrt_pkg::TEMP_LO_BITS-1:0]; // [R1]
    tempHiByte = temp_reg[TEMP_W-1:crrt_pkg::TEMP_HI_LSB]; // [R1]
  end

  // ****************************************************************
  // Temperature result and high byte hold
  // ****************************************************************
  // A fresh conversion may land between the host's read of the low
  // byte and its read of the high byte. The high byte is therefore
  // held when the low byte is read, and the held copy answers the
  // next high byte read, so a low-then-high pair is always coherent.
  always_comb begin
    temp_next = temp_reg;
    hiHold_next = hiHold_reg;
    hiHeld_next = hiHeld_reg;
    if (tempCodeValid) begin
      temp_next = tempCode; // [R2]
    end
    if (hostRdEn && rdRegion == crrt_pkg::REGION_TEMP_LO) begin
      hiHold_next = tempHiByte;
      hiHeld_next = 1'b1;
    end else if (hostRdEn && rdRegion == crrt_pkg::REGION_TEMP_HI) begin
      hiHeld_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      temp_reg <= crrt_pkg::TEMP_RESET; // [R1]
      hiHold_reg <= crrt_pkg::READ_ZERO;
      hiHeld_reg <= 1'b0;
    end else if (ce) begin
      temp_reg <= temp_next;
      hiHold_reg <= hiHold_next;
      hiHeld_reg <= hiHeld_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Test addresses and anything past them answer zero; the host is
  // not meant to go there, but a stray read must not hang the bus.
  always_comb begin
    rdValid_next = hostRdEn;
    rdData_next = rdData_reg;
    if (hostRdEn) begin
      case (rdRegion)
        crrt_pkg::REGION_LOW_BANK: begin
          rdData_next = extRdData;
        end
        crrt_pkg::REGION_EXT: begin
          rdData_next = extRdData;
        end
        crrt_pkg::REGION_TEMP_LO: begin
          rdData_next = tempLoByte; // [R1]
        end
        crrt_pkg::REGION_TEMP_HI: begin
          rdData_next = hiHeld_reg ? hiHold_reg : tempHiByte; // [R1]
        end
        crrt_pkg::REGION_CTRL: begin
          rdData_next = ctl.value;
        end
        default: begin
          rdData_next = crrt_pkg::READ_ZERO; // [R6]
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData_reg <= crrt_pkg::READ_ZERO;
      rdValid_reg <= 1'b0;
    end else if (ce) begin
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  // ****************************************************************
  // Write path to other banks
  // ****************************************************************
  // Low-bank writes pass only while the gate is open. Result bytes and
  // the test range have no write path at all; such writes vanish.
  always_comb begin
    extWrEn_next = 1'b0;
    extWrAddr_next = extWrAddr_reg;
    extWrData_next = extWrData_reg;
    blocked_next = 1'b0;
    if (hostWrEn) begin
      case (wrRegion)
        crrt_pkg::REGION_LOW_BANK: begin
          if (gateOpen) begin
            extWrEn_next = 1'b1; // [R3]
            extWrAddr_next = hostAddr;
            extWrData_next = hostWrData;
          end else begin
            blocked_next = 1'b1; // [R7]
          end
        end
        crrt_pkg::REGION_EXT: begin
          extWrEn_next = 1'b1;
          extWrAddr_next = hostAddr;
          extWrData_next = hostWrData;
        end
        default: begin
          extWrEn_next = 1'b0; // [R7]
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      extWrEn_reg <= 1'b0;
      extWrAddr_reg <= crrt_pkg::ADDR_LOW_FIRST;
      extWrData_reg <= crrt_pkg::READ_ZERO;
      blocked_reg <= 1'b0;
    end else if (ce) begin
      extWrEn_reg <= extWrEn_next;
      extWrAddr_reg <= extWrAddr_next;
      extWrData_reg <= extWrData_next;
      blocked_reg <= blocked_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Code 0 selects no documented strength; the pad logic decides.
  assign padPullupSelect =
    ctl.value[crrt_pkg::CTRL_PULLUP_LSB +: crrt_pkg::CTRL_PULLUP_W]; // [R4]
  assign lowBankWrAllow = gateOpen;
  assign hostRdData = rdData_reg;
  assign hostRdValid = rdValid_reg;
  assign extWrEn = extWrEn_reg;
  assign extWrAddr = extWrAddr_reg;
  assign extWrData = extWrData_reg;
  assign lowBankWrBlocked = blocked_reg;

endmodule

`default_nettype wire

//--- bench/crrt_reg_tail_checker.sv
// Port checker for the receiver register tail.
`timescale 1ns/1ps
`default_nettype none

module crrt_reg_tail_checker (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Host side
  input wire logic hostRdEn,
  input wire logic hostWrEn,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid,
  // Watched outputs
  input wire logic extWrEn,
  input wire logic [7:0] extWrAddr,
  input wire logic [7:0] extWrData,
  input wire logic lowBankWrBlocked,
  input wire logic [1:0] padPullupSelect,
  input wire logic lowBankWrAllow
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire logic lowWr = ce && hostWrEn && hostAddr <= 8'h0F;
  wire logic ctrlWr = ce && hostWrEn && hostAddr == 8'h40;

  read_answer_a: assert property (ce && hostRdEn |=> hostRdValid)
    else $error("read answer missing");
  // A frozen clock enable holds the answer flag, so only judge it after an
  // enabled edge.
  answer_cause_a: assert property (hostRdValid && $past(ce) |->
    $past(hostRdEn))
    else $error("read answer without request");
  result_ro_a: assert property (ce && hostWrEn &&
    hostAddr inside {[8'h3E:8'h3F]} |=> !extWrEn)
    else $error("result byte write forwarded");
  gate_block_a: assert property (lowWr && !lowBankWrAllow
    |=> lowBankWrBlocked && !extWrEn)
    else $error("gated write not dropped");
  gate_pass_a: assert property (lowWr && lowBankWrAllow |=> extWrEn
    && extWrAddr == $past(hostAddr) && extWrData == $past(hostWrData))
    else $error("allowed write not forwarded");
  ctrl_write_a: assert property (ctrlWr |=>
    padPullupSelect == $past(hostWrData[5:4])
    && lowBankWrAllow == $past(hostWrData[0]))
    else $error("control write not applied");
  ctrl_hold_a: assert property (ce && !ctrlWr |=>
    $stable(padPullupSelect) && $stable(lowBankWrAllow))
    else $error("control byte changed unasked");
  ctrl_read_a: assert property (ce && hostRdEn && hostAddr == 8'h40
    |=> hostRdData[5:4] == padPullupSelect
    && hostRdData[0] == lowBankWrAllow)
    else $error("control readback differs");
  blocked_cause_a: assert property (lowBankWrBlocked |->
    $past(hostWrEn) && $past(hostAddr) <= 8'h0F)
    else $error("blocked pulse without low write");
endmodule

bind crrt_reg_tail crrt_reg_tail_checker chk (
  .mclk(mclk), .rst(rst), .ce(ce), .hostRdEn(hostRdEn),
  .hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostRdData(hostRdData), .hostRdValid(hostRdValid), .extWrEn(extWrEn),
  .extWrAddr(extWrAddr), .extWrData(extWrData),
  .lowBankWrBlocked(lowBankWrBlocked), .padPullupSelect(padPullupSelect),
  .lowBankWrAllow(lowBankWrAllow));

`default_nettype wire

//--- bench/crrt_host_model.sv
// Host model issuing byte reads and writes to the register tail.
`timescale 1ns/1ps
`default_nettype none

module crrt_host_model (
  // Clock
  input wire logic mclk,
  // Byte requests
  output logic hostRdEn,
  output logic hostWrEn,
  output logic [7:0] hostAddr,
  output logic [7:0] hostWrData,
  // Read answer
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid
);
  initial begin
    hostRdEn = 1'b0;
    hostWrEn = 1'b0;
    hostAddr = 8'h00;
    hostWrData = 8'h00;
  end

  // Released lines show inverted values so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h41 && a <= 8'h6F) return;
    @(posedge mclk);
    hostWrEn <= 1'b1;
    hostAddr <= a;
    hostWrData <= (a == 8'h40) ? {2'b00, d[5:0]} : d;
    @(posedge mclk);
    hostWrEn <= 1'b0;
    hostAddr <= ~a;
    hostWrData <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge mclk);
    hostRdEn <= 1'b1;
    hostAddr <= a;
    @(posedge mclk);
    hostRdEn <= 1'b0;
    hostAddr <= ~a;
    #1;
    d = hostRdData;
    v = hostRdValid;
  endtask
endmodule

`default_nettype wire

//--- bench/crrt_reg_tail_tb.sv
// Self-checking testbench for the receiver register tail.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin \
  errorCnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end

module crrt_reg_tail_tb;
  logic mclk, rst, ce, tempCodeValid, rdValid;
  logic [11:0] tempCode;
  logic [7:0] extRdData, rdData;
  wire logic hostRdEn, hostWrEn, hostRdValid, extWrEn;
  wire logic lowBankWrBlocked, lowBankWrAllow;
  wire logic [7:0] hostAddr, hostWrData, hostRdData, extWrAddr, extWrData;
  wire logic [1:0] padPullupSelect;
  int errorCnt = 0;
  int checksDone = 0;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  crrt_reg_tail DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .hostRdEn(hostRdEn), .hostWrEn(hostWrEn), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .tempCode(tempCode),
    .tempCodeValid(tempCodeValid), .extRdData(extRdData),
    .extWrEn(extWrEn), .extWrAddr(extWrAddr), .extWrData(extWrData),
    .lowBankWrBlocked(lowBankWrBlocked),
    .padPullupSelect(padPullupSelect), .lowBankWrAllow(lowBankWrAllow));

  crrt_host_model host (.mclk(mclk), .hostRdEn(hostRdEn),
    .hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid));

  // ****
  // Helpers
  // ****
  task finish_test;
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [7:0] e);
    host.rd(a, rdData, rdValid);
    `CHK("rdValid", 1'b1, rdValid)
    `CHK(n, e, rdData)
  endtask

  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdc("tempLo", 8'h3E, 8'h00);
    rdc("tempHi", 8'h3F, 8'h00);
    rdc("ctrl", 8'h40, 8'h00);
    `CHK("pullup", 2'h0, padPullupSelect)
  endtask

  task automatic t_gate;
    host.wr(8'h05, 8'hAA);
    `CHK("blocked", 1'b1, lowBankWrBlocked)
    `CHK("fwd", 1'b0, extWrEn)
    host.wr(8'h40, 8'h01);
    `CHK("allow", 1'b1, lowBankWrAllow)
    host.wr(8'h0F, 8'h3C);
    `CHK("fwd", 1'b1, extWrEn)
    `CHK("fwdAddr", 8'h0F, extWrAddr)
    `CHK("fwdData", 8'h3C, extWrData)
    host.wr(8'h40, 8'h00);
    host.wr(8'h00, 8'h11);
    `CHK("blocked", 1'b1, lowBankWrBlocked)
    host.wr(8'h10, 8'h22);
    `CHK("fwd", 1'b1, extWrEn)
  endtask

  task automatic t_pullup;
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {2'b00, c[1:0], 4'h1};
      host.wr(8'h40, v);
      `CHK("pullup", c[1:0], padPullupSelect)
      rdc("ctrl", 8'h40, v);
    end
  endtask

  // A write while the clock enable is low must leave the control byte alone.
  task automatic t_ce;
    @(posedge mclk);
    ce <= 1'b0;
    host.wr(8'h40, 8'h20);
    `CHK("frozenAllow", 1'b1, lowBankWrAllow)
    `CHK("frozenPullup", 2'h3, padPullupSelect)
    @(posedge mclk);
    ce <= 1'b1;
  endtask

  task automatic t_ext;
    rdc("lowBank", 8'h05, 8'h5A);
    rdc("extBank", 8'h3D, 8'h5A);
    rdc("unmapped", 8'h70, 8'h00);
  endtask

  task automatic t_temp;
    logic [11:0] codes[2];
    codes = '{12'hABC, 12'hFFF};
    foreach (codes[i]) begin
      @(posedge mclk);
      tempCodeValid <= 1'b1;
      tempCode <= codes[i];
      @(posedge mclk);
      tempCodeValid <= 1'b0;
      host.wr(8'h3E, 8'h0F);
      `CHK("fwd", 1'b0, extWrEn)
      rdc("tempLo", 8'h3E, {codes[i][3:0], 4'h0});
      host.wr(8'h3F, 8'h00);
      rdc("tempHi", 8'h3F, codes[i][11:4]);
    end
    // A new conversion between the two byte reads must not tear the pair.
    rdc("tempLo", 8'h3E, 8'hF0);
    @(posedge mclk);
    tempCodeValid <= 1'b1;
    tempCode <= 12'h123;
    @(posedge mclk);
    tempCodeValid <= 1'b0;
    rdc("tempHiHeld", 8'h3F, 8'hFF);
    rdc("tempHiLive", 8'h3F, 8'h12);
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tempCode = 12'h000;
    tempCodeValid = 1'b0;
    extRdData = 8'h5A;
    do_reset();
    t_reset();
    t_gate();
    t_pullup();
    t_ce();
    t_ext();
    t_temp();
    do_reset();
    t_reset();
    finish_test();
  end

  initial begin
    #2_000_000;
    errorCnt++;
    $display("[FAIL] run exp done got hang");
    finish_test();
  end
endmodule

`default_nettype wire
